//--- rtl/plso_pkg.sv
// constants and types for the pointer literal and stack instruction executor
package plso_pkg;

   // ----------------------------------------------------------------
   // widths and reset values
   // ----------------------------------------------------------------
   localparam int PLSO_PTR_W = 12;
   localparam int PLSO_NUM_PTR = 3;
   localparam logic [PLSO_PTR_W-1:0] PLSO_PTR_RST = 12'h000;
   localparam logic [7:0] PLSO_BYTE_RST = 8'h00;

   // ----------------------------------------------------------------
   // opcode fields
   // ----------------------------------------------------------------
   localparam logic [7:0] PLSO_SUB_HI = 8'hE9;
   localparam logic [7:0] PLSO_PUSH_HI = 8'hFA;
   localparam logic [8:0] PLSO_MOVE_P1 = 9'h1D7;
   localparam logic [3:0] PLSO_MOVE_P2 = 4'hF;
   localparam logic [1:0] PLSO_SEL_MAX = 2'h2;
   localparam logic [1:0] PLSO_SEL_TWO = 2'h2;
   localparam int PLSO_LIT6_W = 6;
   localparam int PLSO_OFS_W = 7;
   localparam int PLSO_SEL_LSB = 6;
   localparam int PLSO_HI_LSB = 8;
   localparam int PLSO_P1_LSB = 7;
   localparam int PLSO_P2_LSB = 12;

   // ----------------------------------------------------------------
   // control states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      PLSO_IDLE = 2'h1,
      PLSO_SRC  = 2'h2
   } plso_state_t;

endpackage

//--- rtl/plso_ptr_reg.sv
// one file select pointer with core load and literal subtract
`timescale 1ns/1ns
module plso_ptr_reg
   import plso_pkg::*;
#(
   parameter int PTR_W = PLSO_PTR_W
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // core load
   input wire logic load_en,
   input wire logic [PTR_W-1:0] load_val,
   // instruction subtract
   input wire logic sub_en,
   input wire logic [PTR_W-1:0] sub_val,
   // pointer value
   output logic [PTR_W-1:0] ptr_q
);

   logic [PTR_W-1:0] ptr_d;

   if (PTR_W < PLSO_OFS_W + 1) begin : g_bad_w
      $error("pointer width too small for offsets");
   end

   // ----------------------------------------------------------------
   // next value
   // ----------------------------------------------------------------
   always_comb begin
      ptr_d = ptr_q;
      if (sub_en) begin
         ptr_d = PTR_W'(ptr_q - sub_val);
      end else if (load_en) begin
         ptr_d = load_val;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         ptr_q <= PTR_W'(PLSO_PTR_RST);
      end else begin
         ptr_q <= ptr_d;
      end
   end

endmodule // plso_ptr_reg

//--- rtl/plso_top.sv
// executor for literal push, pointer subtract and indexed move
// How it works
// - pointer subtract takes an unsigned 6-bit literal from the selected pointer
// - subtract decodes from upper byte E9h, selector bits 7:6, literal 5:0
// - result lands in same pointer in one cycle, selector 3 refused, no flags
// - push word FAh writes literal at pointer two, then pointer two minus one
// - move takes two words, each 7-bit offset added to pointer two
`timescale 1ns/1ns
module plso_top
   import plso_pkg::*;
#(
   parameter int PTR_W = PLSO_PTR_W
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // instruction words
   input wire logic instr_valid,
   input wire logic [15:0] instr_word,
   // execution status
   output logic move_pend_q,
   output logic illegal_q,
   // pointer load from core
   input wire logic load_en,
   input wire logic [1:0] load_sel,
   input wire logic [PTR_W-1:0] load_val,
   // pointer values
   output logic [PTR_W-1:0] ptr0_q,
   output logic [PTR_W-1:0] ptr1_q,
   output logic [PTR_W-1:0] ptr2_q,
   // data memory
   output logic mem_re_q,
   output logic mem_we_q,
   output logic [PTR_W-1:0] mem_addr_q,
   output logic [7:0] mem_wdata_q,
   input wire logic [7:0] mem_rdata
);

   plso_state_t state_q;
   plso_state_t state_d;
   logic mem_re_d;
   logic mem_we_d;
   logic [PTR_W-1:0] mem_addr_d;
   logic [7:0] mem_wdata_d;
   logic illegal_d;
   logic [PTR_W-1:0] ptr_w [PLSO_NUM_PTR];
   logic sub_en [PLSO_NUM_PTR];
   logic [PTR_W-1:0] sub_val [PLSO_NUM_PTR];
   logic is_sub;
   logic is_push;
   logic is_mv1;
   logic is_mv2;
   logic [1:0] sel;
   logic [PTR_W-1:0] lit6;
   logic [7:0] lit8;
   logic [PTR_W-1:0] ofs;
   logic [PTR_W-1:0] idx_addr;

   // ----------------------------------------------------------------
   // pointer file
   // ----------------------------------------------------------------
   for (genvar i = 0; i < PLSO_NUM_PTR; i++) begin : g_ptr
      plso_ptr_reg #(
         .PTR_W(PTR_W)
      ) u_ptr (
         .clock(clock),
         .rst(rst),
         .load_en(load_en && (load_sel == 2'(i))),
         .load_val(load_val),
         .sub_en(sub_en[i]),
         .sub_val(sub_val[i]),
         .ptr_q(ptr_w[i])
      );
   end

   assign ptr0_q = ptr_w[0];
   assign ptr1_q = ptr_w[1];
   assign ptr2_q = ptr_w[2];

   // ----------------------------------------------------------------
   // word decode
   // ----------------------------------------------------------------
   always_comb begin
      is_sub = instr_word[15:PLSO_HI_LSB] == PLSO_SUB_HI;
      sel = instr_word[PLSO_SEL_LSB+1:PLSO_SEL_LSB];
      lit6 = PTR_W'(instr_word[PLSO_LIT6_W-1:0]);
      is_push = instr_word[15:PLSO_HI_LSB] == PLSO_PUSH_HI;
      lit8 = instr_word[7:0];
      is_mv1 = instr_word[15:PLSO_P1_LSB] == PLSO_MOVE_P1;
      is_mv2 = instr_word[15:PLSO_P2_LSB] == PLSO_MOVE_P2;
      ofs = PTR_W'(instr_word[PLSO_OFS_W-1:0]);
      idx_addr = PTR_W'(ptr_w[2] + ofs);
   end

   // ----------------------------------------------------------------
   // execution control
   // ----------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      mem_re_d = 1'b0;
      mem_we_d = 1'b0;
      mem_addr_d = mem_addr_q;
      mem_wdata_d = mem_wdata_q;
      illegal_d = 1'b0;
      for (int i = 0; i < PLSO_NUM_PTR; i++) begin
         sub_en[i] = 1'b0;
         sub_val[i] = PTR_W'(1);
      end
      case (state_q)
         PLSO_IDLE: begin
            if (instr_valid) begin
               if (is_sub) begin
                  if (sel > PLSO_SEL_MAX) begin
                     illegal_d = 1'b1;
                  end
                  for (int i = 0; i < PLSO_NUM_PTR; i++) begin
                     if (sel == 2'(i)) begin
                        sub_en[i] = 1'b1;
                        sub_val[i] = lit6;
                     end
                  end
               end else if (is_push) begin
                  mem_we_d = 1'b1;
                  mem_addr_d = ptr_w[2];
                  mem_wdata_d = lit8;
                  sub_en[2] = 1'b1;
                  sub_val[2] = PTR_W'(1);
               end else if (is_mv1) begin
                  state_d = PLSO_SRC;
                  mem_re_d = 1'b1;
                  mem_addr_d = idx_addr;
               end else begin
                  illegal_d = 1'b1;
               end
            end
         end
         PLSO_SRC: begin
            mem_re_d = 1'b1;
            if (instr_valid) begin
               mem_re_d = 1'b0;
               state_d = PLSO_IDLE;
               if (is_mv2) begin
                  mem_we_d = 1'b1;
                  mem_addr_d = idx_addr;
                  mem_wdata_d = mem_rdata;
               end else begin
                  illegal_d = 1'b1;
               end
            end
         end
         default: begin
            state_d = PLSO_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         state_q <= PLSO_IDLE;
         mem_re_q <= 1'b0;
         mem_we_q <= 1'b0;
         mem_addr_q <= PTR_W'(PLSO_PTR_RST);
         mem_wdata_q <= PLSO_BYTE_RST;
         illegal_q <= 1'b0;
         move_pend_q <= 1'b0;
      end else begin
         state_q <= state_d;
         mem_re_q <= mem_re_d;
         mem_we_q <= mem_we_d;
         mem_addr_q <= mem_addr_d;
         mem_wdata_q <= mem_wdata_d;
         illegal_q <= illegal_d;
         move_pend_q <= state_d == PLSO_SRC;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   sub_zero_a: assert property (instr_valid && state_q == PLSO_IDLE && is_sub && sel == 2'h0 |=>
      ptr0_q == PTR_W'($past(ptr0_q) - PTR_W'($past(instr_word[5:0]))))
      else $error("pointer zero subtract wrong");

   sub_two_a: assert property (instr_valid && state_q == PLSO_IDLE && is_sub && sel == PLSO_SEL_TWO |=>
      ptr2_q == PTR_W'($past(ptr2_q) - PTR_W'($past(instr_word[5:0]))) && !mem_we_q && !illegal_q)
      else $error("pointer two subtract wrong");

   sub_bad_sel_a: assert property (instr_valid && state_q == PLSO_IDLE && is_sub && sel == 2'h3 |=>
      illegal_q && ($past(load_en) || $stable(ptr0_q) && $stable(ptr1_q) && $stable(ptr2_q)))
      else $error("selector three not refused");

   push_write_a: assert property (instr_valid && state_q == PLSO_IDLE && is_push |=>
      mem_we_q && mem_addr_q == $past(ptr2_q) && mem_wdata_q == $past(instr_word[7:0]))
      else $error("push write wrong");

   push_dec_a: assert property (instr_valid && state_q == PLSO_IDLE && is_push |=>
      ptr2_q == PTR_W'($past(ptr2_q) - PTR_W'(1)) ##1 !mem_we_q || $past(instr_valid))
      else $error("push decrement wrong");

   move_src_a: assert property (instr_valid && state_q == PLSO_IDLE && is_mv1 |=>
      mem_re_q && move_pend_q && mem_addr_q == PTR_W'($past(ptr2_q) + PTR_W'($past(instr_word[6:0]))))
      else $error("move source address wrong");

   move_dst_a: assert property (instr_valid && state_q == PLSO_SRC && is_mv2 |=>
      mem_we_q && !mem_re_q && mem_wdata_q == $past(mem_rdata) && !move_pend_q
      && mem_addr_q == PTR_W'($past(ptr2_q) + PTR_W'($past(instr_word[6:0]))))
      else $error("move destination write wrong");

   move_ptr_a: assert property (instr_valid && state_q == PLSO_IDLE && is_mv1 ##1 instr_valid && is_mv2 && !load_en
      && !$past(load_en) |=> $stable(ptr2_q))
      else $error("move changed pointer two");

   mem_excl_a: assert property (!(mem_re_q && mem_we_q))
      else $error("read and write together");

   push_cov: cover property (instr_valid && state_q == PLSO_IDLE && is_push ##1 mem_we_q);
   sub_cov: cover property (instr_valid && state_q == PLSO_IDLE && is_sub && sel == 2'h1);
   move_cov: cover property (instr_valid && state_q == PLSO_IDLE && is_mv1 ##1 instr_valid && is_mv2 ##1 mem_we_q);
   move_wait_cov: cover property (instr_valid && state_q == PLSO_IDLE && is_mv1 ##1 !instr_valid [*2] ##1 instr_valid);

endmodule // plso_top

//--- dv/tb.sv
// self-checking bench for the pointer literal and stack executor
`timescale 1ns/1ns
module tb;
   import plso_pkg::*;
   localparam int W = PLSO_PTR_W;
   localparam int MSK = (1 << W) - 1;
   localparam logic [7:0] HI [5] = '{8'hE9, 8'hFA, 8'hEB, 8'hF0, 8'h12};
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic instr_valid = 1'b0;
   logic [15:0] instr_word = 16'h0000;
   logic load_en = 1'b0;
   logic [1:0] load_sel = 2'h0;
   logic [W-1:0] load_val = '0;
   logic move_pend_q, illegal_q, mem_re_q, mem_we_q;
   logic [W-1:0] ptr0_q, ptr1_q, ptr2_q, mem_addr_q;
   logic [7:0] mem_wdata_q, mem_rdata;
   logic [7:0] mem [1 << W];
   logic [7:0] mm [1 << W];
   logic [7:0] cnt = 8'h00;
   logic [15:0] seed = 16'h000D;
   int ep [3];
   int pend, src;
   int fail_count = 0;
   int tests_run = 0;

   // ----------------------------------------------------------------
   // clock, memory and design
   // ----------------------------------------------------------------
   always #5 clock = ~clock;
   always @(posedge clock) begin
      cnt <= cnt + 8'h01;
      if (mem_we_q) mem[mem_addr_q] <= mem_wdata_q;
   end
   // unselected read data keeps changing
   assign mem_rdata = mem_re_q ? mem[mem_addr_q] : cnt;

   plso_top #(.PTR_W(W)) plso_top_i (
      .clock(clock), .rst(rst), .instr_valid(instr_valid), .instr_word(instr_word),
      .move_pend_q(move_pend_q), .illegal_q(illegal_q), .load_en(load_en),
      .load_sel(load_sel), .load_val(load_val), .ptr0_q(ptr0_q), .ptr1_q(ptr1_q),
      .ptr2_q(ptr2_q), .mem_re_q(mem_re_q), .mem_we_q(mem_we_q),
      .mem_addr_q(mem_addr_q), .mem_wdata_q(mem_wdata_q), .mem_rdata(mem_rdata)
   );

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic done(input string n);
      $display("test %s finished", n);
   endtask

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // one cycle of stimulus, then model update and compare
   task automatic exec(input logic v, input logic [15:0] w, input logic le = 1'b0,
                       input logic [1:0] ls = 2'h0, input logic [W-1:0] lv = '0);
      int t, ewe, eill, eaddr, ewd;
      t = -1;
      ewe = 0;
      eill = 0;
      eaddr = -1;
      ewd = 0;
      instr_valid = v;
      instr_word = w;
      load_en = le;
      load_sel = ls;
      load_val = lv;
      @(posedge clock);
      #1;
      if (v && pend) begin
         pend = 0;
         if (w[15:12] == 4'hF) begin
            ewe = 1;
            eaddr = (ep[2] + w[6:0]) & MSK;
            ewd = src;
         end else eill = 1;
      end else if (v && w[15:8] == 8'hE9) begin
         if (w[7:6] == 2'h3) eill = 1;
         else begin
            t = w[7:6];
            ep[t] = (ep[t] - w[5:0]) & MSK;
         end
      end else if (v && w[15:8] == 8'hFA) begin
         ewe = 1;
         eaddr = ep[2];
         ewd = w[7:0];
         t = 2;
         ep[2] = (ep[2] - 1) & MSK;
      end else if (v && w[15:7] == 9'h1D7) begin
         pend = 1;
         eaddr = (ep[2] + w[6:0]) & MSK;
         src = mm[eaddr];
      end else if (v) eill = 1;
      if (le && ls != 2'h3 && ls != t) ep[ls] = lv;
      if (ewe) mm[eaddr] = 8'(ewd);
      chk("ptr0", 16'(ep[0]), 16'(ptr0_q));
      chk("ptr1", 16'(ep[1]), 16'(ptr1_q));
      chk("ptr2", 16'(ep[2]), 16'(ptr2_q));
      chk("illegal", 16'(eill), 16'(illegal_q));
      chk("move_pend", 16'(pend), 16'(move_pend_q));
      chk("mem_re", 16'(pend), 16'(mem_re_q));
      chk("mem_we", 16'(ewe), 16'(mem_we_q));
      if (eaddr >= 0) chk("mem_addr", 16'(eaddr), 16'(mem_addr_q));
      if (ewe) chk("mem_wdata", 16'(ewd), 16'(mem_wdata_q));
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      for (int i = 0; i < (1 << W); i++) begin
         mem[i] = 8'(i * 7);
         mm[i] = 8'(i * 7);
      end
      mem[12'h085] = 8'h33;
      mm[12'h085] = 8'h33;
      mem[12'h086] = 8'h11;
      mm[12'h086] = 8'h11;
      pend = 0;
      ep = '{0, 0, 0};
      repeat (2) @(posedge clock);
      #1;
      rst = 1'b0;
      exec(1'b0, 16'h0000);
      done("reset");
      for (int s = 0; s < 4; s++) begin
         seed = lfsr(seed);
         exec(1'b0, 16'h0000, 1'b1, 2'(s), seed[W-1:0]);
      end
      done("load");
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         exec(1'b1, {8'hE9, 2'(i), (i == 0 ? 6'h3F : seed[5:0])});
      end
      done("subtract");
      exec(1'b0, 16'h0000, 1'b1, 2'h2, 12'h001);
      for (int i = 0; i < 3; i++) begin
         seed = lfsr(seed);
         exec(1'b1, {8'hFA, seed[7:0]});
      end
      exec(1'b0, 16'h0000);
      done("push");
      exec(1'b0, 16'h0000, 1'b1, 2'h2, 12'h080);
      exec(1'b1, 16'hEB85);
      exec(1'b0, 16'h0000);
      exec(1'b0, 16'h0000);
      exec(1'b1, 16'hF006);
      exec(1'b0, 16'h0000);
      chk("dest_byte", 16'h0033, 16'(mem[12'h086]));
      exec(1'b1, 16'hEB81);
      exec(1'b1, 16'hFA55);
      exec(1'b1, 16'h0000);
      exec(1'b1, 16'hF006);
      exec(1'b1, 16'hE9C1);
      done("move and refusals");
      exec(1'b1, 16'hE945, 1'b1, 2'h1, 12'h123);
      exec(1'b1, 16'hFA01, 1'b1, 2'h0, 12'h321);
      done("conflict");
      for (int i = 0; i < 60; i++) begin
         seed = lfsr(seed);
         exec(seed[11], {HI[seed[14:12] % 5], seed[7:0]}, seed[15], seed[13:12],
              {seed[3:0], seed[15:8]});
      end
      done("random");
      stop_test();
   end
endmodule // tb
